// *** shared/ivm_cfg.svh ***
// constants of the reset and interrupt vector map
`ifndef IVM_CFG_SVH
`define IVM_CFG_SVH
`define IVM_ADDR_W 16
`define IVM_NUM_W 5
`define IVM_NUM_IRQ 28
`define IVM_RESET_ADDR 16'h0000
`define IVM_BOOT_START_DEF 16'hf000
`define IVM_VEC_RESET 5'h01
`define IVM_VEC_EXTERNAL_REQUEST_ZERO 5'h02
`define IVM_VEC_EXTERNAL_REQUEST_SEVEN 5'h09
`define IVM_VEC_PIN_CHANGE_REQUEST_ZERO 5'h0a
`define IVM_VEC_WATCHDOG_TIMEOUT 5'h0d
`define IVM_VEC_T2_COMPARE_MATCH_A 5'h0e
`define IVM_VEC_T1_CAPTURE_EVENT 5'h11
`define IVM_VEC_T0_COUNTER_OVERFLOW 5'h18
`define IVM_VEC_SERIAL_TRANSFER_COMPLETE 5'h19
`define IVM_VEC_RX_COMPLETE 5'h1a
`define IVM_VEC_TRANSMIT_BUFFER_EMPTY 5'h1b
`define IVM_VEC_ANALOG_COMPARE 5'h1d
`define IVM_ADDR_EXTERNAL_REQUEST_ZERO 16'h0002
`define IVM_ADDR_EXTERNAL_REQUEST_SEVEN 16'h0010
`define IVM_ADDR_PIN_CHANGE_REQUEST_ZERO 16'h0012
`define IVM_ADDR_WATCHDOG_TIMEOUT 16'h0018
`define IVM_ADDR_T2_COMPARE_MATCH_A 16'h001a
`define IVM_ADDR_T1_CAPTURE_EVENT 16'h0020
`define IVM_ADDR_T0_COUNTER_OVERFLOW 16'h002e
`define IVM_ADDR_SERIAL_TRANSFER_COMPLETE 16'h0030
`define IVM_ADDR_TRANSMIT_BUFFER_EMPTY 16'h0034
`define IVM_ADDR_ANALOG_COMPARE 16'h0038
`define IVM_START_CNT 2'h2
`endif

// *** shared/ivm_pkg.sv ***
// types of the reset and interrupt vector map
`include "ivm_cfg.svh"
package ivm_pkg;
	typedef logic [`IVM_ADDR_W-1:0] ivm_addr_t;
	typedef logic [`IVM_NUM_W-1:0] ivm_num_t;
	typedef logic [`IVM_NUM_IRQ-1:0] ivm_irq_vec_t;
	typedef enum logic [1:0] {IVM_ST_START, IVM_ST_RUN} ivm_state_t;
endpackage

// *** shared/ivm_win_if.sv ***
// winner of the pending requests, passed from encoder to the top
`timescale 1ns/1ps
interface ivm_win_if;
	import ivm_pkg::*;
	logic valid;
	ivm_num_t num;
	modport enc (output valid, output num);
	modport top (input valid, input num);
endinterface

// *** verilog/ivm_prio_enc.sv ***
// lowest-index-first priority encoder over the pending requests
`timescale 1ns/1ps
`include "ivm_cfg.svh"
module ivm_prio_enc
	import ivm_pkg::*;
#(
	parameter int N = `IVM_NUM_IRQ
)
(
	// requests, bit 0 is vector 2
	input wire logic [N-1:0] req,
	// winner
	ivm_win_if.enc win
);
	logic [N:0] lower_any;
	logic [N-1:0] onehot;
	ivm_num_t idx;

	assign lower_any[0] = 1'b0;
	genvar i;
	generate
		for (i = 0; i < N; i++)
		begin : g_chain
			assign onehot[i] = req[i] & ~lower_any[i];
			assign lower_any[i+1] = lower_any[i] | req[i];
		end
	endgenerate

	always_comb
	begin
		idx = '0;
		for (int k = 0; k < N; k++)
		begin
			if (onehot[k])
				idx = ivm_num_t'(k);
		end
	end

	assign win.valid = lower_any[N];
	assign win.num = idx + `IVM_VEC_EXTERNAL_REQUEST_ZERO;
endmodule

// *** verilog/ivm_vector_map.sv ***
// reset and interrupt vector map with priority selection
//
// What this block does
// - every reset cause enters at one reset vector, address zero unless the boot reset fuse is programmed.
// - external requests 0..7 are vectors 2..9 at 0x0002 to 0x0010.
// - pin change 0..2 at 0x0012..0x0016, watchdog time-out at 0x0018.
// - second 8-bit timer: compare A 0x001A, compare B 0x001C, overflow 0x001E.
// - 16-bit timer: capture 0x0020, compares 0x0022..0x0026, overflow 0x0028.
// - first 8-bit timer: compare A 0x002A, compare B 0x002C, overflow 0x002E.
// - serial transfer complete at 0x0030, analog comparator at 0x0038.
// - serial unit receive 0x0032, buffer empty 0x0034, transmit done 0x0036.
// - vector select bit moves all interrupt vectors up by boot start.
// - programmed boot reset fuse makes reset enter at the boot address.
`timescale 1ns/1ps
`include "ivm_cfg.svh"
module ivm_vector_map
	import ivm_pkg::*;
#(
	parameter ivm_addr_t BOOT_START = `IVM_BOOT_START_DEF
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// configuration
	input wire logic boot_reset_fuse,
	input wire logic vector_select_bit,
	input wire logic global_irq_enable,
	// requests from peripherals, bit 0 is vector 2
	input wire ivm_irq_vec_t irq_src,
	// core side
	output logic reset_fetch,
	output ivm_addr_t reset_addr,
	output logic irq_req,
	output ivm_num_t irq_num,
	output ivm_addr_t irq_addr,
	input wire logic irq_ack,
	output ivm_irq_vec_t irq_taken
);
	ivm_win_if win ();
	ivm_state_t state_r, state_nxt;
	logic [1:0] cnt_r;
	logic fuse_s1_r, fuse_s2_r, fuse_r;
	logic reset_fetch_r, req_r, req_nxt;
	ivm_addr_t reset_addr_r, addr_r, addr_nxt;
	ivm_num_t num_r;
	ivm_irq_vec_t taken_r, taken_nxt;
	logic take, start_done;
	ivm_addr_t base;

	function automatic ivm_addr_t vec_offset(input ivm_num_t n);
		vec_offset = ivm_addr_t'({n, 1'b0}) - ivm_addr_t'(2);
	endfunction

	ivm_prio_enc #(.N(`IVM_NUM_IRQ)) u_enc (
		.req(irq_src),
		.win(win)
	);

	assign start_done = (state_r == IVM_ST_START) && (cnt_r == `IVM_START_CNT);
	assign take = req_r & irq_ack;
	assign base = vector_select_bit ? BOOT_START : `IVM_RESET_ADDR;
	assign addr_nxt = base + vec_offset(win.num);
	assign req_nxt = (state_r == IVM_ST_RUN) & win.valid & global_irq_enable & ~take & ~(|taken_r);
	assign taken_nxt = take ? (ivm_irq_vec_t'(1) << (num_r - `IVM_VEC_EXTERNAL_REQUEST_ZERO)) : '0;

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			IVM_ST_START:
				if (cnt_r == `IVM_START_CNT)
					state_nxt = IVM_ST_RUN;
			IVM_ST_RUN:
				state_nxt = IVM_ST_RUN;
			default:
				state_nxt = IVM_ST_START;
		endcase
	end

	// strap sync, then capture once after release
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			fuse_s1_r <= 1'b0;
			fuse_s2_r <= 1'b0;
		end
		else
		begin
			fuse_s1_r <= boot_reset_fuse;
			fuse_s2_r <= fuse_s1_r;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_r <= IVM_ST_START;
			cnt_r <= 2'h0;
			fuse_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			if (state_r == IVM_ST_START)
				cnt_r <= cnt_r + 2'h1;
			if (start_done)
				fuse_r <= fuse_s2_r;
		end
	end

	// one reset entry for every cause
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			reset_fetch_r <= 1'b0;
			reset_addr_r <= `IVM_RESET_ADDR;
		end
		else
		begin
			reset_fetch_r <= start_done;
			if (start_done)
				reset_addr_r <= fuse_s2_r ? BOOT_START : `IVM_RESET_ADDR;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			req_r <= 1'b0;
			num_r <= `IVM_VEC_EXTERNAL_REQUEST_ZERO;
			addr_r <= `IVM_RESET_ADDR;
			taken_r <= '0;
		end
		else
		begin
			req_r <= req_nxt;
			taken_r <= taken_nxt;
			if (!take)
			begin
				num_r <= win.num;
				addr_r <= addr_nxt;
			end
		end
	end

	assign reset_fetch = reset_fetch_r;
	assign reset_addr = reset_addr_r;
	assign irq_req = req_r;
	assign irq_num = num_r;
	assign irq_addr = addr_r;
	assign irq_taken = taken_r;

	// checks
	property p_map(ivm_num_t n, ivm_addr_t a);
		@(posedge clk) disable iff (!rst_b)
		(req_r && num_r == n && !$past(vector_select_bit)) |-> addr_r == a;
	endproperty

	chk_reset_entry_zero: assert property (@(posedge clk) disable iff (!rst_b)
		(reset_fetch_r && !fuse_r) |-> reset_addr_r == `IVM_RESET_ADDR)
		else $error("reset entry not at address zero");
	chk_ext_req_map: assert property (p_map(`IVM_VEC_EXTERNAL_REQUEST_SEVEN,
		`IVM_ADDR_EXTERNAL_REQUEST_SEVEN))
		else $error("external request seven misplaced");
	chk_watchdog_map: assert property (p_map(`IVM_VEC_WATCHDOG_TIMEOUT, `IVM_ADDR_WATCHDOG_TIMEOUT))
		else $error("watchdog vector misplaced");
	chk_pin_change_map: assert property (p_map(`IVM_VEC_PIN_CHANGE_REQUEST_ZERO,
		`IVM_ADDR_PIN_CHANGE_REQUEST_ZERO))
		else $error("pin change request zero misplaced");
	chk_transfer_map: assert property (p_map(`IVM_VEC_SERIAL_TRANSFER_COMPLETE,
		`IVM_ADDR_SERIAL_TRANSFER_COMPLETE))
		else $error("serial transfer complete vector misplaced");
	chk_timer2_map: assert property (p_map(`IVM_VEC_T2_COMPARE_MATCH_A, `IVM_ADDR_T2_COMPARE_MATCH_A))
		else $error("second 8-bit timer vector misplaced");
	chk_timer1_map: assert property (p_map(`IVM_VEC_T1_CAPTURE_EVENT, `IVM_ADDR_T1_CAPTURE_EVENT))
		else $error("16-bit timer capture vector misplaced");
	chk_timer0_map: assert property (p_map(`IVM_VEC_T0_COUNTER_OVERFLOW, `IVM_ADDR_T0_COUNTER_OVERFLOW))
		else $error("first 8-bit timer overflow misplaced");
	chk_comparator_map: assert property (p_map(`IVM_VEC_ANALOG_COMPARE, `IVM_ADDR_ANALOG_COMPARE))
		else $error("analog comparator vector misplaced");
	chk_serial_map: assert property (p_map(`IVM_VEC_TRANSMIT_BUFFER_EMPTY,
		`IVM_ADDR_TRANSMIT_BUFFER_EMPTY))
		else $error("buffer empty vector misplaced");
	chk_relocate_boot: assert property (@(posedge clk) disable iff (!rst_b)
		(req_r && $past(vector_select_bit) && !$past(take)) |-> addr_r == BOOT_START + vec_offset(num_r))
		else $error("vector not relocated to boot section");
	chk_boot_reset: assert property (@(posedge clk) disable iff (!rst_b)
		reset_fetch_r |-> reset_addr_r == (fuse_r ? BOOT_START : `IVM_RESET_ADDR))
		else $error("reset entry ignores boot fuse");
	chk_addr_formula: assert property (@(posedge clk) disable iff (!rst_b)
		(req_r && !$past(vector_select_bit)) |-> addr_r == ({11'h000, num_r} << 1) - 16'h0002)
		else $error("vector address not twice number minus two");
	chk_lowest_wins: assert property (@(posedge clk) disable iff (!rst_b)
		(req_r && !$past(take)) |-> ($past(irq_src) & ((ivm_irq_vec_t'(1) << (num_r - 5'h02)) - 1'b1)) == '0)
		else $error("lower pending request skipped");
	chk_ack_taken: assert property (@(posedge clk) disable iff (!rst_b)
		take |=> (|taken_r) ##1 !req_r)
		else $error("ack not followed by taken pulse");

	cov_reset_boot: cover property (@(posedge clk) disable iff (!rst_b) reset_fetch_r && fuse_r);
	cov_two_pending: cover property (@(posedge clk) disable iff (!rst_b) req_r && $countones(irq_src) > 1);
	cov_relocated_take: cover property (@(posedge clk) disable iff (!rst_b) take && vector_select_bit);
endmodule

// *** testbench/ivm_core_model.sv ***
// processor core model that acknowledges offered interrupts
`timescale 1ns/1ps
module ivm_core_model
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// cycles of standing offer before the acknowledge
	input wire logic [3:0] ack_dly,
	// block side
	input wire logic irq_req,
	output logic irq_ack
);
	logic [3:0] seen_cnt;
	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			irq_ack <= 1'b0;
			seen_cnt <= 4'h0;
		end
		else
		begin
			seen_cnt <= irq_req ? seen_cnt + 4'h1 : 4'h0;
			// hold the acknowledge until the edge that sees the offer with it
			if (irq_ack && irq_req)
				irq_ack <= #1 1'b0;
			else if (!irq_ack && irq_req && seen_cnt >= ack_dly)
				irq_ack <= #1 1'b1;
		end
	end
endmodule

// *** testbench/interrupt_vector_map_bench.sv ***
// self-checking bench of the reset and interrupt vector map
`timescale 1ns/1ps
module interrupt_vector_map_bench import ivm_pkg::*;;
	localparam ivm_addr_t BST = 16'h1c00;
	logic clk, rst_b, fuse, vsel, gie, ack, r_fetch, req;
	logic [3:0] dly;
	ivm_addr_t r_addr, i_addr;
	ivm_num_t i_num;
	ivm_irq_vec_t src, taken;
	int error_cnt, compares;
	ivm_vector_map #(.BOOT_START(BST)) uut (.clk(clk), .rst_b(rst_b), .boot_reset_fuse(fuse),
		.vector_select_bit(vsel), .global_irq_enable(gie), .irq_src(src), .reset_fetch(r_fetch),
		.reset_addr(r_addr), .irq_req(req), .irq_num(i_num), .irq_addr(i_addr), .irq_ack(ack),
		.irq_taken(taken));
	ivm_core_model core (.clk(clk), .rst_b(rst_b), .ack_dly(dly), .irq_req(req), .irq_ack(ack));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic close_out;
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [27:0] got, input logic [27:0] exp, input string what);
		compares++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic tick;
		@(posedge clk);
		#1;
	endtask
	task automatic restart(input logic f);
		int k;
		rst_b = 1'b0;
		fuse = f;
		src = '0;
		repeat (16) tick;
		rst_b = 1'b1;
		for (k = 0; k < 6 && r_fetch !== 1'b1; k++)
			tick;
		if (k == 6)
		begin
			error_cnt++;
			close_out;
		end
		chk(28'(k), 28'd3, "reset entry edge");
		chk(28'(r_addr), f ? 28'(BST) : 28'h0, "reset address");
		tick;
		chk(28'(r_fetch), 28'h0, "reset fetch pulse");
	endtask
	// wait for the offer, check it, let the core take it, drop the source
	task automatic serve(input int v);
		int k;
		ivm_addr_t exp_a;
		exp_a = 16'(2 * v - 2) + (vsel ? BST : 16'h0000);
		for (k = 0; k < 20 && req !== 1'b1; k++)
			tick;
		if (k == 20)
		begin
			error_cnt++;
			close_out;
		end
		chk(28'(i_num), 28'(v), "vector number");
		chk(28'(i_addr), 28'(exp_a), "vector address");
		for (k = 0; k < 20 && taken === '0; k++)
			tick;
		if (k == 20)
		begin
			error_cnt++;
			close_out;
		end
		chk(taken, 28'h1 << (v - 2), "taken pulse");
		src[v - 2] = 1'b0;
	endtask
	task automatic test_map;
		for (int s = 0; s < 2; s++)
		begin
			vsel = s[0];
			for (int i = 0; i < 28; i++)
			begin
				dly = 4'(i % 4);
				src[i] = 1'b1;
				serve(i + 2);
				tick;
			end
		end
		vsel = 1'b0;
		$display("test map done");
	endtask
	task automatic test_prio;
		dly = 4'h2;
		src = 28'h800_0220;
		serve(7);
		serve(11);
		serve(29);
		tick;
		$display("test priority done");
	endtask
	task automatic test_gate;
		gie = 1'b0;
		src[0] = 1'b1;
		repeat (8)
		begin
			tick;
			chk(28'(req), 28'h0, "masked offer");
		end
		gie = 1'b1;
		serve(2);
		$display("test gate done");
	endtask
	initial
	begin
		rst_b = 1'b0;
		fuse = 1'b0;
		vsel = 1'b0;
		gie = 1'b1;
		dly = 4'h0;
		src = '0;
		error_cnt = 0;
		compares = 0;
		restart(1'b1);
		restart(1'b0);
		$display("test reset done");
		test_map;
		test_prio;
		test_gate;
		close_out;
	end
endmodule
